// ==== rtl/hpil_pkg.sv ====
// Shared constants and types for the host port and interrupt logic.
package hpil_pkg;
    localparam int unsigned CH_N = 8;
    localparam int unsigned GRP_N = 4;
    typedef logic [7:0] hpil_byte_t;
    typedef logic [4:0] hpil_addr_t;
    typedef logic [GRP_N-1:0][CH_N-1:0] hpil_grp_t;
    // Group index of each interrupt source.
    localparam int unsigned GRP_SIL   = 0;
    localparam int unsigned GRP_SHORT = 1;
    localparam int unsigned GRP_ALARM = 2;
    localparam int unsigned GRP_LOOP  = 3;
    // Primary bank offsets.
    localparam hpil_addr_t ADDR_SIL_STAT   = 5'h04;
    localparam hpil_addr_t ADDR_SHORT_STAT = 5'h05;
    localparam hpil_addr_t ADDR_SIL_MASK   = 5'h06;
    localparam hpil_addr_t ADDR_SHORT_MASK = 5'h07;
    localparam hpil_addr_t ADDR_SIL_FLAG   = 5'h08;
    localparam hpil_addr_t ADDR_SHORT_FLAG = 5'h09;
    localparam hpil_addr_t ADDR_ALARM_STAT = 5'h13;
    localparam hpil_addr_t ADDR_ALARM_MASK = 5'h14;
    localparam hpil_addr_t ADDR_ALARM_FLAG = 5'h15;
    // Expanded bank offsets; the bank pointer offset is decoded for writes in both banks.
    localparam hpil_addr_t ADDR_LOOP_STAT  = 5'h0b;
    localparam hpil_addr_t ADDR_LOOP_MASK  = 5'h0c;
    localparam hpil_addr_t ADDR_LOOP_FLAG  = 5'h0d;
    localparam hpil_addr_t ADDR_BANK_PTR   = 5'h1f;
    localparam hpil_byte_t BANK_EXP_KEY    = 8'haa;
    localparam hpil_byte_t BANK_RST        = 8'h00;
    localparam hpil_byte_t MASK_RST        = 8'h00;
    localparam hpil_byte_t FLAG_RST        = 8'h00;
    // Serial frame layout.
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CMD_BITS   = 5'h08;
    localparam int unsigned CMD_RW_BIT = 0;
    // Cycles of filtered pins before the straps are captured.
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    typedef enum logic [2:0] {
        HPIL_NONE, HPIL_SERIAL, HPIL_NM_STROBE, HPIL_NM_RWS, HPIL_MX_STROBE, HPIL_MX_RWS
    } hpil_mode_e;
    typedef struct packed {
        logic serial_mid;
        logic host_port_select;
        logic mux_bus_select;
        logic bus_style_select;
    } hpil_strap_s;
    typedef struct packed {
        logic       cs_n;
        logic       strobe_n;
        logic       rw_wr;
        logic       addr_latch;
        hpil_addr_t addr;
        hpil_byte_t dq;
    } hpil_ppin_s;
    typedef struct packed {
        logic sclk;
        logic scs_n;
        logic serial_in_pin;
    } hpil_spin_s;
endpackage : hpil_pkg

// ==== rtl/hpil_irq.sv ====
// Change detector and latched flags for one interrupt group.
`timescale 1ns/1ps
`default_nettype none
module hpil_irq #(
    parameter int unsigned W = 8
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] status,
    input  wire logic [W-1:0] mask,
    input  wire logic         clr,
    output logic      [W-1:0] flag,
    output logic      [W-1:0] flag_nxt
);
    import hpil_pkg::*;
    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] flag;
    } hpil_irq_s;
    hpil_irq_s q, d;
    logic [W-1:0] hit;

    always_comb begin
        d = q;
        d.prev = status;
        hit = mask & (status ^ q.prev);
        // A change in the clearing cycle survives the clear.
        d.flag = (clr ? '0 : q.flag) | hit;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign flag     = q.flag;
    assign flag_nxt = d.flag;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    flag_set_a: assert property ((mask[0] && (status[0] != q.prev[0])) |=> flag[0])
        else $error("Enabled status change did not set its flag.");
    mask_block_a: assert property ((mask == '0 && !clr) |=> flag == $past(flag))
        else $error("Flag changed while its mask was zero.");
    clr_done_a: assert property ((clr && mask == '0) |=> flag == '0)
        else $error("Status read did not clear the flags.");
    flag_set_c: cover property (clr && (hit != '0));
endmodule : hpil_irq
`default_nettype wire

// ==== rtl/hpil_serial.sv ====
// Serial host port frame engine: command byte, then data byte.
`timescale 1ns/1ps
`default_nettype none
module hpil_serial (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic                 en,
    input  wire logic                 sclk,
    input  wire logic                 scs_n,
    input  wire logic                 serial_in_pin,
    input  wire hpil_pkg::hpil_byte_t rd_data,
    output logic                      rd_req,
    output logic                      wr_req,
    output hpil_pkg::hpil_addr_t      addr,
    output hpil_pkg::hpil_byte_t      wdata,
    output logic                      serial_out_pin,
    output logic                      sdo_oe_n
);
    import hpil_pkg::*;
    typedef struct packed {
        logic       prev_sclk;
        logic [4:0] cnt;
        hpil_byte_t cmd;
        hpil_byte_t dat;
        hpil_byte_t osh;
        logic       loaded;
        logic       serial_out_pin;
        logic       oe_n;
    } hpil_ser_s;
    hpil_ser_s q, d;
    localparam logic [4:0] LAST_BIT = FRAME_BITS - 5'h01;

    always_comb begin
        d = q;
        rd_req = 1'b0;
        wr_req = 1'b0;
        d.prev_sclk = sclk;
        if (!en || scs_n) begin
            d.cnt = '0;
            d.loaded = 1'b0;
            d.oe_n = 1'b1;
        end else begin
            if (sclk && !q.prev_sclk && q.cnt < FRAME_BITS) begin
                if (q.cnt < CMD_BITS) begin
                    d.cmd[q.cnt[2:0]] = serial_in_pin;
                end else begin
                    d.dat = {q.dat[6:0], serial_in_pin};
                end
                d.cnt = q.cnt + 5'h01;
                wr_req = (q.cnt == LAST_BIT) && !q.cmd[CMD_RW_BIT];
            end
            if (q.cnt == CMD_BITS && !q.loaded) begin
                d.loaded = 1'b1;
                if (q.cmd[CMD_RW_BIT]) begin
                    rd_req = 1'b1;
                    d.osh = rd_data;
                end
            end
            if (!sclk && q.prev_sclk && q.loaded && q.cmd[CMD_RW_BIT] && q.cnt < FRAME_BITS) begin
                d.serial_out_pin = q.osh[7];
                d.osh = {q.osh[6:0], 1'b0};
                d.oe_n = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '{default: '0, oe_n: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign addr     = q.cmd[5:1];
    assign wdata    = {q.dat[6:0], serial_in_pin};
    assign serial_out_pin      = q.serial_out_pin;
    assign sdo_oe_n = q.oe_n;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    rd_load_a: assert property (rd_req |=> q.osh == $past(rd_data) && q.loaded)
        else $error("Read data was not loaded for shifting out.");
    wr_point_a: assert property (wr_req |-> q.cnt == LAST_BIT && !q.cmd[CMD_RW_BIT])
        else $error("Write issued outside the last data bit.");
    ser_write_c: cover property (wr_req);
endmodule : hpil_serial
`default_nettype wire

// ==== rtl/hpil_host_port.sv ====
// Host access ports, register decode and shared interrupt output.
`timescale 1ns/1ps
`default_nettype none
module hpil_host_port (
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire hpil_pkg::hpil_strap_s strap,
    input  wire hpil_pkg::hpil_ppin_s  ppin,
    input  wire hpil_pkg::hpil_spin_s  spin,
    input  wire hpil_pkg::hpil_grp_t   status,
    output logic [7:0]                 dq_o,
    output logic                       dq_oe_n,
    output logic                       ack_rdy,
    output logic                       serial_out_pin,
    output logic                       sdo_oe_n,
    output logic                       int_o,
    output logic                       int_oe_n,
    output hpil_pkg::hpil_mode_e       host_mode
);
    import hpil_pkg::*;
    localparam int unsigned PW = $bits(hpil_strap_s) + $bits(hpil_ppin_s) + $bits(hpil_spin_s);
    typedef enum logic [1:0] {P_IDLE, P_WAIT, P_ACT} hpil_pst_e;
    typedef struct packed {
        logic [PW-1:0] s1;
        logic [PW-1:0] s2;
        logic [PW-1:0] s3;
        logic [PW-1:0] f;
        logic [1:0]    boot;
        logic          taken;
        hpil_mode_e    mode;
        hpil_pst_e     pst;
        hpil_addr_t    lat_addr;
        hpil_addr_t    acc_addr;
        logic          acc_rd;
        hpil_byte_t    acc_wd;
        hpil_grp_t     mask;
        hpil_byte_t    bank;
        hpil_byte_t    dq_o;
        logic          dq_oe_n;
        logic          ack_rdy;
        logic          int_o;
        logic          int_oe_n;
    } hpil_top_s;
    hpil_top_s q, d;

    hpil_strap_s sf;
    hpil_ppin_s  pp;
    hpil_spin_s  sp;
    hpil_grp_t   flag, flag_nxt;
    logic [GRP_N-1:0] clr;
    logic        exp_bank, mux, rws, par, strobe_act, is_read;
    hpil_addr_t  paddr;
    logic        s_rd, s_wr;
    hpil_addr_t  s_addr;
    hpil_byte_t  s_wdata, s_rdata;
    logic        wr_en;
    hpil_addr_t  wr_addr;
    hpil_byte_t  wr_data;

    // Parallel strap code to port variant; the serial strap overrides it.
    function automatic hpil_mode_e hpil_decode(input hpil_strap_s s);
        hpil_mode_e m;
        m = HPIL_NONE;
        if (s.serial_mid) begin
            m = HPIL_SERIAL;
        end else if (s.host_port_select) begin
            case ({s.mux_bus_select, s.bus_style_select})
                2'b00: m = HPIL_NM_STROBE;
                2'b01: m = HPIL_NM_RWS;
                2'b10: m = HPIL_MX_STROBE;
                2'b11: m = HPIL_MX_RWS;
                default: m = HPIL_NONE;
            endcase
        end
        return m;
    endfunction : hpil_decode

    // Read decode; status comes straight from the status inputs, flags from the detectors.
    function automatic hpil_byte_t hpil_read(input hpil_addr_t a, input logic ex,
                                             input hpil_grp_t st, input hpil_grp_t mk,
                                             input hpil_grp_t fl);
        hpil_byte_t r;
        r = 8'h00;
        if (ex) begin
            case (a)
                ADDR_LOOP_STAT: r = st[GRP_LOOP];
                ADDR_LOOP_MASK: r = mk[GRP_LOOP];
                ADDR_LOOP_FLAG: r = fl[GRP_LOOP];
                default:        r = 8'h00;
            endcase
        end else begin
            case (a)
                ADDR_SIL_STAT:   r = st[GRP_SIL];
                ADDR_SHORT_STAT: r = st[GRP_SHORT];
                ADDR_SIL_MASK:   r = mk[GRP_SIL];
                ADDR_SHORT_MASK: r = mk[GRP_SHORT];
                ADDR_SIL_FLAG:   r = fl[GRP_SIL];
                ADDR_SHORT_FLAG: r = fl[GRP_SHORT];
                ADDR_ALARM_STAT: r = st[GRP_ALARM];
                ADDR_ALARM_MASK: r = mk[GRP_ALARM];
                ADDR_ALARM_FLAG: r = fl[GRP_ALARM];
                default:         r = 8'h00;
            endcase
        end
        return r;
    endfunction : hpil_read

    // Which flag group a read of this address clears.
    function automatic logic [GRP_N-1:0] hpil_clr(input hpil_addr_t a, input logic ex);
        logic [GRP_N-1:0] c;
        c = '0;
        if (ex) begin
            c[GRP_LOOP] = (a == ADDR_LOOP_STAT);
        end else begin
            c[GRP_SIL]   = (a == ADDR_SIL_STAT);
            c[GRP_SHORT] = (a == ADDR_SHORT_STAT);
            c[GRP_ALARM] = (a == ADDR_ALARM_STAT);
        end
        return c;
    endfunction : hpil_clr

    assign pp = hpil_ppin_s'(q.f[$bits(hpil_spin_s) +: $bits(hpil_ppin_s)]);
    assign sp = hpil_spin_s'(q.f[$bits(hpil_spin_s)-1:0]);
    assign exp_bank = (q.bank == BANK_EXP_KEY);
    assign s_rdata  = hpil_read(s_addr, exp_bank, status, q.mask, flag);

    hpil_serial u_serial (
        .mclk     (mclk),
        .rstn     (rstn),
        .en       (q.mode == HPIL_SERIAL),
        .sclk     (sp.sclk),
        .scs_n    (sp.scs_n),
        .serial_in_pin      (sp.serial_in_pin),
        .rd_data  (s_rdata),
        .rd_req   (s_rd),
        .wr_req   (s_wr),
        .addr     (s_addr),
        .wdata    (s_wdata),
        .serial_out_pin      (serial_out_pin),
        .sdo_oe_n (sdo_oe_n)
    );

    for (genvar g = 0; g < GRP_N; g++) begin : g_irq
        hpil_irq #(.W(CH_N)) u_irq (
            .mclk     (mclk),
            .rstn     (rstn),
            .status   (status[g]),
            .mask     (q.mask[g]),
            .clr      (clr[g]),
            .flag     (flag[g]),
            .flag_nxt (flag_nxt[g])
        );
    end

    always_comb begin
        d = q;
        clr = '0;
        wr_en = 1'b0;
        wr_addr = s_addr;
        wr_data = s_wdata;
        // Three-stage pin filter: a bit moves only when stages two and three agree.
        d.s1 = {strap, ppin, spin};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.f  = ((q.s2 ~^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.f);
        // The filter starts from zeros, so its first true value is the one formed at the fourth edge.
        sf = hpil_strap_s'(d.f[PW-1 -: $bits(hpil_strap_s)]);
        if (q.boot != STRAP_SETTLE) begin
            d.boot = q.boot + 2'h1;
        end else if (!q.taken) begin
            d.taken = 1'b1;
            d.mode = hpil_decode(sf);
        end
        mux = (q.mode == HPIL_MX_STROBE) || (q.mode == HPIL_MX_RWS);
        rws = (q.mode == HPIL_NM_RWS) || (q.mode == HPIL_MX_RWS);
        par = (q.mode != HPIL_NONE) && (q.mode != HPIL_SERIAL);
        strobe_act = rws ? (!pp.strobe_n || !pp.rw_wr) : !pp.strobe_n;
        is_read = rws ? !pp.strobe_n : pp.rw_wr;
        if (mux && (rws ? pp.addr_latch : !pp.addr_latch)) begin
            d.lat_addr = pp.dq[4:0];
        end
        paddr = mux ? q.lat_addr : pp.addr;
        if (s_rd) begin
            clr = hpil_clr(s_addr, exp_bank);
        end
        wr_en = s_wr;
        case (q.pst)
            P_IDLE: begin
                d.ack_rdy = 1'b1;
                if (par && !pp.cs_n && strobe_act) begin
                    d.acc_addr = paddr;
                    d.acc_rd = is_read;
                    d.acc_wd = pp.dq;
                    d.ack_rdy = !rws;
                    d.pst = P_WAIT;
                end
            end
            P_WAIT: begin
                if (q.acc_rd) begin
                    d.dq_o = hpil_read(q.acc_addr, exp_bank, status, q.mask, flag);
                    d.dq_oe_n = 1'b0;
                    clr = hpil_clr(q.acc_addr, exp_bank);
                end else begin
                    wr_en = 1'b1;
                    wr_addr = q.acc_addr;
                    wr_data = q.acc_wd;
                end
                d.ack_rdy = rws;
                d.pst = P_ACT;
            end
            P_ACT: begin
                if (pp.cs_n || !strobe_act) begin
                    d.dq_oe_n = 1'b1;
                    d.ack_rdy = 1'b1;
                    d.pst = P_IDLE;
                end
            end
            default: d.pst = P_IDLE;
        endcase
        if (wr_en) begin
            if (wr_addr == ADDR_BANK_PTR) begin
                d.bank = wr_data;
            end else if (exp_bank) begin
                if (wr_addr == ADDR_LOOP_MASK) d.mask[GRP_LOOP] = wr_data;
            end else begin
                case (wr_addr)
                    ADDR_SIL_MASK:   d.mask[GRP_SIL] = wr_data;
                    ADDR_SHORT_MASK: d.mask[GRP_SHORT] = wr_data;
                    ADDR_ALARM_MASK: d.mask[GRP_ALARM] = wr_data;
                    default:         d.bank = q.bank;
                endcase
            end
        end
        // Only ever pull low; the pull-up supplies the high level.
        d.int_o = 1'b0;
        d.int_oe_n = ~|flag_nxt;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '{default: '0, mode: HPIL_NONE, pst: P_IDLE, mask: {GRP_N{MASK_RST}},
                   bank: BANK_RST, dq_oe_n: 1'b1, ack_rdy: 1'b1, int_oe_n: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign dq_o      = q.dq_o;
    assign dq_oe_n   = q.dq_oe_n;
    assign ack_rdy   = q.ack_rdy;
    assign int_o     = q.int_o;
    assign int_oe_n  = q.int_oe_n;
    assign host_mode = q.mode;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    int_release_a: assert property (int_oe_n == (flag == '0))
        else $error("Interrupt pin does not match pending flags.");
    int_drain_a: assert property (!int_o)
        else $error("Interrupt pin driven high.");
    ack_style_a: assert property ((q.pst == P_WAIT && !rws) |=> !ack_rdy)
        else $error("Strobe-style access not acknowledged.");
    rdy_style_a: assert property ((q.pst == P_WAIT && rws) |=> ack_rdy && q.pst == P_ACT)
        else $error("Read/write-strobe access not marked ready.");
    par_read_a: assert property ((q.pst == P_WAIT && q.acc_rd) |=> !dq_oe_n)
        else $error("Parallel read did not drive the data bus.");
    mask_write_a: assert property ((s_wr && s_addr == ADDR_SIL_MASK && !exp_bank) |=>
        q.mask[GRP_SIL] == $past(s_wdata))
        else $error("Serial write did not reach the silence mask.");
    par_read_c: cover property (q.pst == P_WAIT && q.acc_rd);
    int_low_c: cover property ($fell(int_oe_n));
endmodule : hpil_host_port
`default_nettype wire

// ==== verif/hpil_host_model.sv ====
// Host processor model for all parallel port variants and the serial port.
`timescale 1ns/1ps
`default_nettype none
module hpil_host_model (
    input  wire logic                 mclk,
    input  wire logic                 rws,
    input  wire logic                 mux,
    input  wire logic                 ack_rdy,
    input  wire hpil_pkg::hpil_byte_t dq_o,
    input  wire logic                 serial_out_pin,
    input  wire logic                 sdo_oe_n,
    output var  hpil_pkg::hpil_ppin_s ppin,
    output var  hpil_pkg::hpil_spin_s spin
);
    import hpil_pkg::*;
    initial ppin = {1'b1, 1'b1, 1'b1, 1'b1, 5'h00, 8'h5a};
    initial spin = 3'b010;
    // One access: held until done (acknowledge low, or ready back high after busy), then released.
    task automatic acc(input logic rd, input hpil_addr_t a, input hpil_byte_t w,
                       output hpil_byte_t r, output logic ok);
        int n;
        logic busy;
        n = 0;
        ok = 1'b0;
        busy = 1'b0;
        r = 8'h00;
        @(negedge mclk);
        if (mux) begin
            // Address phase; the latch strobe is high-active only in read/write-strobe style.
            ppin.dq = {3'h0, a};
            ppin.addr_latch = rws;
            repeat (6) @(negedge mclk);
            ppin.addr_latch = !rws;
        end
        ppin.addr = a;
        ppin.rw_wr = rd;
        ppin.dq = rd ? ~w : w;
        ppin.cs_n = 1'b0;
        ppin.strobe_n = rws && !rd;
        while (n < 20 && !ok) begin
            @(posedge mclk);
            n++;
            if (rws ? (busy && ack_rdy === 1'b1) : (ack_rdy === 1'b0)) begin
                ok = 1'b1;
                r = dq_oe_n_seen(dq_o);
            end
            busy = busy || (ack_rdy === 1'b0);
        end
        @(negedge mclk);
        ppin.cs_n = 1'b1;
        ppin.strobe_n = 1'b1;
        ppin.rw_wr = 1'b1;
        // A released bus must not look like the last value driven.
        ppin.dq = ~ppin.dq;
        n = 0;
        while (n < 20 && ack_rdy !== 1'b1) begin
            @(posedge mclk);
            n++;
        end
        repeat (6) @(negedge mclk);
    endtask : acc

    // An undriven data bus reads back as the inverse of what the port holds.
    function automatic hpil_byte_t dq_oe_n_seen(input hpil_byte_t v);
        return (testbench.dq_oe_n === 1'b0) ? v : ~v;
    endfunction : dq_oe_n_seen

    // One serial frame: command bits from the read/write bit up, then data D7 first.
    task automatic ser(input logic rd, input hpil_addr_t a, input hpil_byte_t w, output hpil_byte_t r);
        hpil_byte_t cmd;
        cmd = {2'b11, a, rd};
        r = 8'h00;
        @(negedge mclk);
        spin.scs_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            spin.sclk = 1'b0;
            spin.serial_in_pin = (i < 8) ? cmd[i] : w[15 - i];
            repeat (8) @(negedge mclk);
            if (i >= 8) r = {r[6:0], (sdo_oe_n === 1'b0) ? serial_out_pin : ~serial_out_pin};
            spin.sclk = 1'b1;
            repeat (8) @(negedge mclk);
        end
        spin.sclk = 1'b0;
        spin.scs_n = 1'b1;
        repeat (8) @(negedge mclk);
    endtask : ser
endmodule : hpil_host_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the host port and interrupt logic.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hpil_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    hpil_strap_s strap = 4'b0100;
    hpil_ppin_s  ppin;
    hpil_spin_s  spin;
    logic        rws_sel = 1'b0;
    logic        mux_sel = 1'b0;
    hpil_grp_t   status = '0;
    hpil_byte_t  dq_o, r;
    logic        dq_oe_n, ack_rdy, serial_out_pin, sdo_oe_n, int_o, int_oe_n, ok;
    hpil_mode_e  host_mode;
    int          failures = 0;
    int          checks = 0;
    logic [3:0]  row_strap [6] = '{4'b1000, 4'b0100, 4'b0101, 4'b0110, 4'b0111, 4'b0000};
    hpil_mode_e  row_mode [6] = '{HPIL_SERIAL, HPIL_NM_STROBE, HPIL_NM_RWS, HPIL_MX_STROBE, HPIL_MX_RWS, HPIL_NONE};

    hpil_host_port uut (.mclk(mclk), .rstn(rstn), .strap(strap), .ppin(ppin), .spin(spin), .status(status),
        .dq_o(dq_o), .dq_oe_n(dq_oe_n), .ack_rdy(ack_rdy), .serial_out_pin(serial_out_pin), .sdo_oe_n(sdo_oe_n), .int_o(int_o),
        .int_oe_n(int_oe_n), .host_mode(host_mode));
    hpil_host_model hst (.mclk(mclk), .rws(rws_sel), .mux(mux_sel), .ack_rdy(ack_rdy), .dq_o(dq_o), .serial_out_pin(serial_out_pin),
        .sdo_oe_n(sdo_oe_n), .ppin(ppin), .spin(spin));

    initial forever #20 mclk = ~mclk;

    task automatic wrap_up();
        if (failures == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic rd(input hpil_addr_t a, input hpil_byte_t exp, input string nm);
        hst.acc(1'b1, a, 8'h00, r, ok);
        chk({nm, " ack"}, {7'h00, ok}, 8'h01);
        chk(nm, r, exp);
        chk({nm, " oe"}, {7'h00, dq_oe_n}, 8'h01);
    endtask : rd

    task automatic wr(input hpil_addr_t a, input hpil_byte_t d);
        hst.acc(1'b0, a, d, r, ok);
        chk("write ack", {7'h00, ok}, 8'h01);
    endtask : wr

    task automatic do_reset(input logic [3:0] s);
        @(negedge mclk);
        rstn = 1'b0;
        strap = s;
        repeat (12) @(negedge mclk);
        rstn = 1'b1;
        repeat (8) @(negedge mclk);
    endtask : do_reset

    // Status is sampled without filtering, so a few cycles cover the flag latency.
    task automatic tog(input int g, input int b);
        @(negedge mclk);
        status[g][b] = ~status[g][b];
        repeat (3) @(negedge mclk);
    endtask : tog

    task automatic irq(input logic exp);
        chk("int_oe_n", {7'h00, int_oe_n}, {7'h00, exp});
        chk("int_o", {7'h00, int_o}, 8'h00);
    endtask : irq

    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        wrap_up();
    end

    initial begin
        for (int i = 0; i < 6; i++) begin
            do_reset(row_strap[i]);
            chk("host_mode", {5'h00, host_mode}, {5'h00, row_mode[i]});
        end
        do_reset(4'b0100);
        irq(1'b1);
        rd(ADDR_SIL_MASK, MASK_RST, "sil_mask");
        tog(0, 0);
        irq(1'b1);
        rd(ADDR_SIL_FLAG, 8'h00, "sil_flag");
        wr(ADDR_SIL_MASK, 8'hff);
        rd(ADDR_SIL_STAT, 8'h01, "sil_stat");
        tog(0, 2);
        irq(1'b0);
        rd(ADDR_SIL_FLAG, 8'h04, "sil_flag");
        rd(ADDR_SIL_FLAG, 8'h04, "sil_flag");
        rd(ADDR_SIL_STAT, 8'h05, "sil_stat");
        rd(ADDR_SIL_FLAG, 8'h00, "sil_flag");
        irq(1'b1);
        rd(ADDR_SIL_STAT, 8'h05, "sil_stat");
        tog(0, 2);
        rd(ADDR_SIL_FLAG, 8'h04, "sil_flag");
        rd(ADDR_SIL_STAT, 8'h01, "sil_stat");
        wr(ADDR_SHORT_MASK, 8'hff);
        wr(ADDR_ALARM_MASK, 8'hff);
        tog(1, 1);
        tog(2, 3);
        rd(ADDR_SHORT_FLAG, 8'h02, "short_flag");
        rd(ADDR_SHORT_STAT, 8'h02, "short_stat");
        irq(1'b0);
        rd(ADDR_ALARM_FLAG, 8'h08, "alarm_flag");
        rd(ADDR_ALARM_STAT, 8'h08, "alarm_stat");
        irq(1'b1);
        wr(ADDR_BANK_PTR, BANK_EXP_KEY);
        wr(ADDR_LOOP_MASK, 8'h80);
        tog(3, 7);
        tog(3, 6);
        rd(ADDR_LOOP_FLAG, 8'h80, "loop_flag");
        rd(ADDR_LOOP_STAT, 8'hc0, "loop_stat");
        irq(1'b1);
        wr(ADDR_BANK_PTR, BANK_RST);
        rd(ADDR_SIL_MASK, 8'hff, "sil_mask");
        do_reset(4'b0111);
        rws_sel = 1'b1;
        mux_sel = 1'b1;
        wr(ADDR_SHORT_MASK, 8'h5a);
        rd(ADDR_SHORT_MASK, 8'h5a, "mx_short_mask");
        rd(ADDR_SIL_MASK, 8'h00, "mx_sil_mask");
        rws_sel = 1'b0;
        mux_sel = 1'b0;
        do_reset(4'b1000);
        hst.ser(1'b0, ADDR_SIL_MASK, 8'h3c, r);
        hst.ser(1'b1, ADDR_SIL_MASK, 8'h00, r);
        chk("ser_sil_mask", r, 8'h3c);
        tog(0, 2);
        irq(1'b0);
        hst.ser(1'b1, ADDR_SIL_STAT, 8'h00, r);
        chk("ser_sil_stat", r, 8'h05);
        irq(1'b1);
        chk("sdo_oe_n", {7'h00, sdo_oe_n}, 8'h01);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
